/* File: design/deser_lock_ctrl.sv */
// lock acquisition, pclk source select and output control
`timescale 1ns/1ps
module deser_lock_ctrl
   import deser_pkg::*;
#(
   parameter bit          SPREAD_VARIANT = 1'b0,
   parameter int          REF_LOCK_CYC   = SPREAD_VARIANT ? REF_LOCK_SPREAD
                                                          : REF_LOCK_PLAIN,
   parameter int          TIMEOUT_LIM    = TIMEOUT_CYC,
   parameter int          BLANK_LIM      = BLANK_BITS,
   parameter logic [19:0] TRANS_RESET    = TRANS_WORD_DEF
)
(
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   input  wire logic                  refClkIn,
   input  wire logic                  powerDownN,
   input  wire logic                  outputDriveEn,
   input  wire logic                  risingLatch,
   input  wire logic                  spreadSel,
   input  wire logic [1:0]            rateBandSel,
   input  wire logic                  serialBit,
   input  wire logic                  serialStrobe,
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   input  wire logic                  we_i,
   input  wire logic [ADR_W-1:0]      adr_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic [31:0]           dat_i,
   output logic [31:0]                dat_o,
   output logic                       ack_o,
   output logic                       lockN,
   output logic                       lockOe,
   output logic                       pclkOut,
   output logic                       dataOe,
   output logic [VIDEO_BITS-1:0]      videoWordOut,
   output logic [CTRL_BITS-1:0]       controlWordOut,
   output logic                       videoPhaseFlag,
   output logic                       slewFast,
   output spread_t                    spreadOut
);

   pins_t       pinRaw;
   pins_t       pinMeta;
   pins_t       pins;
   lock_state_t state;
   logic        refPrev;
   logic        refRise;
   logic        lastBit;
   logic [7:0]  gapCnt;
   logic        active;
   logic [WORD_BITS-1:0] sh;
   logic [WORD_BITS-1:0] shNext;
   logic [4:0]  bitCnt;
   logic        wordStrobe;
   logic        matchHit;
   logic [15:0] refCnt;
   logic [22:0] toCnt;
   logic        toTick;
   logic        timeout;
   logic [8:0]  settleCnt;
   logic [14:0] blankCnt;
   logic        ssPrev;
   logic [WORD_BITS-1:0] transWord;
   logic        relockReq;
   dec_word_t   dec;
   logic        dataValid;
   logic [VIDEO_BITS-1:0] vidNew;
   logic        stgRun;
   logic [3:0]  stgCnt;
   logic        recLevel;
   logic        useRec;
   logic        useRecPrev;
   logic [1:0]  stretchCnt;
   logic        pclkRaw;
   logic        wbHit;

   assign pinRaw = '{band: rateBandSel, spread: spreadSel,
                     rising: risingLatch, output_drive_en: outputDriveEn,
                     pwrN: powerDownN, local_reference_clock: refClkIn};

   // pin synchroniser
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pinMeta <= '0;
         pins    <= '0;
      end
      else if (ce)
      begin
         pinMeta <= pinRaw;
         pins    <= pinMeta;
      end
   end

   assign refRise = pins.local_reference_clock & ~refPrev;

   // serial activity watch
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         refPrev <= 1'b0;
         lastBit <= 1'b0;
         gapCnt  <= 8'h00;
      end
      else if (ce)
      begin
         refPrev <= pins.local_reference_clock;
         if (serialStrobe)
         begin
            lastBit <= serialBit;
         end
         if (serialStrobe && serialBit != lastBit)
         begin
            gapCnt <= 8'h00;
         end
         else if (gapCnt != 8'(ACT_GAP_CYC))
         begin
            gapCnt <= gapCnt + 8'h01;
         end
      end
   end

   assign active = gapCnt != 8'(ACT_GAP_CYC);

   // word assembly, LSB first
   assign shNext     = {serialBit, sh[WORD_BITS-1:1]};
   assign wordStrobe = serialStrobe && bitCnt == 5'(WORD_BITS - 1);
   assign matchHit   = serialStrobe && shNext == transWord
                       && (state == ST_SEARCH || wordStrobe);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sh     <= '0;
         bitCnt <= 5'h00;
      end
      else if (ce && serialStrobe)
      begin
         sh <= shNext;
         if ((state == ST_SEARCH && matchHit) || wordStrobe)
         begin
            bitCnt <= 5'h00;
         end
         else
         begin
            bitCnt <= bitCnt + 5'h01;
         end
      end
   end

   deser_word_decode u_decode (
      .word (shNext),
      .dec  (dec)
   );

   // pclk ticks: reference in search, words once recovered
   assign toTick  = (state == ST_SEARCH) ? refRise : wordStrobe;
   assign timeout = toTick && toCnt == 23'(TIMEOUT_LIM - 1);

   // acquisition state machine
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state     <= ST_OFF;
         refCnt    <= 16'h0000;
         toCnt     <= 23'h00_0000;
         settleCnt <= 9'h000;
      end
      else if (ce)
      begin
         if (!pins.pwrN)
         begin
            state <= ST_OFF;
         end
         else
         begin
            unique case (state)
               ST_OFF:
               begin
                  state  <= ST_REFLOCK;
                  refCnt <= 16'h0000;
               end
               ST_REFLOCK:
               begin
                  if (refRise)
                  begin
                     refCnt <= refCnt + 16'h0001;
                     if (refCnt == 16'(REF_LOCK_CYC - 1))
                     begin
                        state <= ST_SEARCH;
                        toCnt <= 23'h00_0000;
                     end
                  end
               end
               ST_SEARCH:
               begin
                  if (matchHit)
                  begin
                     state     <= SPREAD_VARIANT ? ST_SETTLE : ST_LOCKED;
                     settleCnt <= 9'h000;
                     toCnt     <= 23'h00_0000;
                  end
                  else if (timeout)
                  begin
                     toCnt <= 23'h00_0000;
                  end
                  else if (toTick)
                  begin
                     toCnt <= toCnt + 23'h00_0001;
                  end
               end
               ST_SETTLE:
               begin
                  if (!active)
                  begin
                     state <= ST_SEARCH;
                  end
                  else if (wordStrobe)
                  begin
                     settleCnt <= settleCnt + 9'h001;
                     if (settleCnt == 9'(SETTLE_CYC - 1))
                     begin
                        state <= ST_LOCKED;
                     end
                  end
               end
               ST_LOCKED:
               begin
                  if (!active || relockReq || timeout)
                  begin
                     state <= ST_SEARCH;
                     toCnt <= 23'h00_0000;
                  end
                  else if (matchHit)
                  begin
                     toCnt <= 23'h00_0000;
                  end
                  else if (toTick)
                  begin
                     toCnt <= toCnt + 23'h00_0001;
                  end
               end
            endcase
         end
      end
   end

   // spread change blanking and modulation phase
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ssPrev    <= 1'b0;
         blankCnt  <= 15'h0000;
         spreadOut <= '0;
      end
      else if (ce)
      begin
         ssPrev <= pins.spread;
         if (SPREAD_VARIANT && pins.spread != ssPrev && state != ST_OFF)
         begin
            blankCnt <= 15'(BLANK_LIM);
         end
         else if (serialStrobe && blankCnt != 15'h0000)
         begin
            blankCnt <= blankCnt - 15'h0001;
         end
         if (!SPREAD_VARIANT)
         begin
            spreadOut <= '0;
         end
         else
         begin
            spreadOut.peakPct <= pins.spread ? PCT_WIDE : PCT_NARROW;
            if (wordStrobe)
            begin
               spreadOut.phase <= spreadOut.phase + 10'h001;
            end
         end
      end
   end

   assign dataValid = state == ST_LOCKED && active && blankCnt == 15'h0000;

   // parallel outputs with staggered video groups
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         videoWordOut   <= '0;
         controlWordOut <= '0;
         videoPhaseFlag <= 1'b0;
         vidNew         <= '0;
         stgRun         <= 1'b0;
         stgCnt         <= 4'h0;
      end
      else if (ce)
      begin
         if (!dataValid)
         begin
            videoWordOut   <= '0;
            controlWordOut <= '0;
            videoPhaseFlag <= 1'b0;
            stgRun         <= 1'b0;
         end
         else if (wordStrobe)
         begin
            videoPhaseFlag <= dec.isVideo;
            if (dec.isVideo)
            begin
               vidNew <= dec.video;
               stgRun <= 1'b1;
               stgCnt <= 4'h0;
            end
            else
            begin
               controlWordOut <= dec.ctrl;
            end
         end
         else if (stgRun)
         begin
            for (int g = 0; g < GROUP_COUNT; g++)
            begin
               if (stgCnt == 4'(g * STAGGER_CYC))
               begin
                  videoWordOut[g*GROUP_BITS +: GROUP_BITS] <=
                     vidNew[g*GROUP_BITS +: GROUP_BITS];
               end
            end
            stgCnt <= stgCnt + 4'h1;
            if (stgCnt == 4'((GROUP_COUNT - 1) * STAGGER_CYC))
            begin
               stgRun <= 1'b0;
            end
         end
      end
   end

   // pclk generation and source switch
   assign useRec = (state == ST_SETTLE || state == ST_LOCKED) && active;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         recLevel   <= 1'b0;
         useRecPrev <= 1'b0;
         stretchCnt <= 2'h0;
         pclkRaw    <= 1'b0;
      end
      else if (ce)
      begin
         // rising mid-word, falling when new data lands
         if (serialStrobe && bitCnt == 5'(MID_BIT))
         begin
            recLevel <= 1'b1;
         end
         else if (wordStrobe)
         begin
            recLevel <= 1'b0;
         end
         useRecPrev <= useRec;
         if (useRec != useRecPrev)
         begin
            stretchCnt <= 2'(STRETCH_CYC);
         end
         else if (stretchCnt != 2'h0)
         begin
            stretchCnt <= stretchCnt - 2'h1;
         end
         else
         begin
            pclkRaw <= useRec ? recLevel : pins.local_reference_clock;
         end
      end
   end

   // lock, enables and edge polarity
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lockN    <= 1'b1;
         lockOe   <= 1'b0;
         dataOe   <= 1'b0;
         pclkOut  <= 1'b0;
         slewFast <= 1'b0;
      end
      else if (ce)
      begin
         lockN  <= !(state == ST_LOCKED && active);
         lockOe <= pins.pwrN;
         dataOe <= pins.pwrN & pins.output_drive_en;
         pclkOut <= pins.rising ? pclkRaw : ~pclkRaw;
         slewFast <= pins.band != BAND_SLOW;
      end
   end

   // wishbone slave, ack one cycle after the request
   function automatic logic [31:0] lanes(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      for (int b = 0; b < 4; b++)
      begin
         old[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
      lanes = old;
   endfunction

   assign wbHit = cyc_i && stb_i;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_o     <= 1'b0;
         dat_o     <= 32'h0000_0000;
         transWord <= TRANS_RESET;
         relockReq <= 1'b0;
      end
      else if (ce)
      begin
         ack_o     <= wbHit && !ack_o;
         relockReq <= 1'b0;
         if (wbHit && !ack_o && !we_i)
         begin
            unique case (adr_i)
               ADR_STATUS: dat_o <= {25'h000_0000, blankCnt != 15'h0000,
                                     videoPhaseFlag, active, lockN, state};
               ADR_TRANS:  dat_o <= {12'h000, transWord};
               default:    dat_o <= 32'h0000_0000;
            endcase
         end
         if (wbHit && ack_o && we_i)
         begin
            if (adr_i == ADR_TRANS)
            begin
               transWord <= WORD_BITS'(lanes({12'h000, transWord}, dat_i,
                                             sel_i));
            end
            if (adr_i == ADR_CTRL && sel_i[0])
            begin
               relockReq <= dat_i[CTRL_RELOCK_BIT];
            end
         end
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n || !ce);

   property p_idle_out;
      !active && state != ST_OFF |=> lockN && videoWordOut == '0;
   endproperty
   a_idle_out: assert property (p_idle_out)
      else $error("idle link left lock or data active");

   property p_pwr_off;
      !pins.pwrN |=> !lockOe && !dataOe;
   endproperty
   a_pwr_off: assert property (p_pwr_off)
      else $error("outputs driven in power-down");

   property p_reflock_out;
      state == ST_REFLOCK |=> lockN && controlWordOut == '0;
   endproperty
   a_reflock_out: assert property (p_reflock_out)
      else $error("lock or data active during reference lock");

   property p_ref_bound;
      state == ST_REFLOCK |-> refCnt < 16'(REF_LOCK_CYC);
   endproperty
   a_ref_bound: assert property (p_ref_bound)
      else $error("reference lock overran its bound");

   property p_lock_low;
      state == ST_LOCKED && active && pins.pwrN |=> !lockN;
   endproperty
   a_lock_low: assert property (p_lock_low)
      else $error("lock not asserted in locked state");

   property p_settle;
      state == ST_SETTLE |-> settleCnt < 9'(SETTLE_CYC) && lockN;
   endproperty
   a_settle: assert property (p_settle)
      else $error("lock asserted before settle count ended");

   property p_stretch;
      stretchCnt != 2'h0 |=> $stable(pclkRaw);
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("pclk moved during source stretch");

   property p_timeout;
      timeout && state == ST_LOCKED && pins.pwrN
         |=> state == ST_SEARCH ##1 lockN;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout did not drop lock");

   property p_blank;
      blankCnt != 15'h0000 |=> videoWordOut == '0 && !videoPhaseFlag;
   endproperty
   a_blank: assert property (p_blank)
      else $error("data active during spread blanking");

   property p_oe_lock;
      pins.pwrN && !pins.output_drive_en |=> lockOe && !dataOe;
   endproperty
   a_oe_lock: assert property (p_oe_lock)
      else $error("output enable misapplied");

   c_locked:  cover property (state == ST_SETTLE ##1 state == ST_LOCKED);
   c_timeout: cover property (timeout && state == ST_SEARCH);
   c_blank:   cover property ($rose(blankCnt != 15'h0000));

endmodule

/* File: design/deser_pkg.sv */
// constants and types for the deserializer lock control
package deser_pkg;

   localparam int WORD_BITS   = 20;
   localparam int VIDEO_BITS  = 18;
   localparam int CTRL_BITS   = 9;
   localparam int VOTED_BITS  = 5;
   localparam int GROUP_BITS  = 6;
   localparam int GROUP_COUNT = 3;
   localparam int VOTE_FIRST  = 1;
   localparam int DIRECT_FIRST = 16;
   localparam int VIDEO_FIRST = 2;
   localparam int FLAG_A_BIT  = 0;
   localparam int FLAG_B_BIT  = 1;
   localparam int MID_BIT     = 9;

   // timing
   localparam int CLK_PERIOD_PS   = 8000;
   localparam int STAGGER_PS      = 1000;
   localparam int STAGGER_CYC_RAW = (STAGGER_PS + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
   localparam int STAGGER_CYC     = (STAGGER_CYC_RAW < 1) ? 1
                                    : STAGGER_CYC_RAW;
   localparam int REF_LOCK_PLAIN  = 16928;
   localparam int REF_LOCK_SPREAD = 33600;
   localparam int SETTLE_CYC      = 288;
   localparam int TIMEOUT_CYC     = 4194304;
   localparam int BLANK_BITS      = 32000;
   localparam int ACT_GAP_CYC     = 64;
   localparam int STRETCH_CYC     = 2;
   localparam int SPREAD_DIV      = 1024;

   localparam logic [1:0] BAND_SLOW   = 2'h1;
   localparam logic [2:0] PCT_WIDE    = 3'h4;
   localparam logic [2:0] PCT_NARROW  = 3'h2;
   localparam logic [19:0] TRANS_WORD_DEF = 20'hF_C00F;

   // register map, byte addresses
   localparam int ADR_W = 4;
   localparam logic [3:0] ADR_STATUS = 4'h0;
   localparam logic [3:0] ADR_TRANS  = 4'h4;
   localparam logic [3:0] ADR_CTRL   = 4'h8;
   localparam int CTRL_RELOCK_BIT = 0;

   typedef enum logic [2:0] {
      ST_OFF     = 3'h0,
      ST_REFLOCK = 3'h1,
      ST_SEARCH  = 3'h3,
      ST_SETTLE  = 3'h2,
      ST_LOCKED  = 3'h6
   } lock_state_t;

   typedef struct packed {
      logic [1:0] band;
      logic       spread;
      logic       rising;
      logic       output_drive_en;
      logic       pwrN;
      logic       local_reference_clock;
   } pins_t;

   typedef struct packed {
      logic                  isVideo;
      logic [VIDEO_BITS-1:0] video;
      logic [CTRL_BITS-1:0]  ctrl;
   } dec_word_t;

   typedef struct packed {
      logic [2:0] peakPct;
      logic [9:0] phase;
   } spread_t;

endpackage

/* File: design/deser_word_decode.sv */
// splits one received 20-bit word into video or control fields
`timescale 1ns/1ps
module deser_word_decode
   import deser_pkg::*;
(
   input  wire logic [WORD_BITS-1:0] word,
   output dec_word_t                 dec
);

   function automatic logic vote3(input logic [2:0] v);
      vote3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   always_comb
   begin
      // flag a tells video from control; flag b inverts video symbols
      dec.isVideo = word[FLAG_A_BIT];
      dec.video   = word[VIDEO_FIRST +: VIDEO_BITS]
                    ^ {VIDEO_BITS{word[FLAG_B_BIT]}};
      // triple copies voted, last four taken as sent
      for (int i = 0; i < VOTED_BITS; i++)
      begin
         dec.ctrl[i] = vote3(word[VOTE_FIRST + 3*i +: 3]);
      end
      dec.ctrl[CTRL_BITS-1:VOTED_BITS] =
         word[DIRECT_FIRST +: CTRL_BITS-VOTED_BITS];
   end

endmodule

/* File: dv/serial_src.sv */
// serializer stand-in streaming 20-bit words onto the link
`timescale 1ns/1ps
module serial_src
   import deser_pkg::*;
#(
   parameter int BIT_CYC = 2
)
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 run,
   input  wire logic [WORD_BITS-1:0] word,
   output logic                      serialBit,
   output logic                      serialStrobe,
   output logic                      wordDone
);
   int                   tick;
   int                   idx;
   logic [WORD_BITS-1:0] cur;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tick <= 0;
         idx <= 0;
         cur <= '0;
         serialBit <= 1'b0;
         serialStrobe <= 1'b0;
         wordDone <= 1'b0;
      end
      else
      begin
         serialStrobe <= 1'b0;
         wordDone <= 1'b0;
         if (!run)
         begin
            // stopped link holds its level
            tick <= 0;
            idx <= 0;
            cur <= word;
         end
         else
         begin
            tick <= (tick == BIT_CYC - 1) ? 0 : tick + 1;
            if (tick == 0)
            begin
               serialBit <= cur[idx];
               serialStrobe <= 1'b1;
               idx <= (idx == WORD_BITS - 1) ? 0 : idx + 1;
               if (idx == WORD_BITS - 1)
               begin
                  cur <= word;
                  wordDone <= 1'b1;
               end
            end
         end
      end
   end
endmodule

/* File: dv/tb_deser_lock_ctrl.sv */
// self-checking bench for the lock and output control block
`timescale 1ns/1ps
module tb_deser_lock_ctrl
   import deser_pkg::*;
;
   logic                  clk, arst_n, refClkIn, powerDownN, output_drive_en, run;
   logic                  cyc, stb, we, ack, lockN, lockOe, pclkOut;
   logic                  dataOe, videoPhaseFlag, slewFast, rising, spread;
   logic                  serialBit, serialStrobe, wordDone;
   logic [1:0]            band;
   logic [3:0]            adr, sel, refHist;
   logic [31:0]           datW, datR, q;
   logic [WORD_BITS-1:0]  word;
   logic [VIDEO_BITS-1:0] videoWordOut;
   logic [CTRL_BITS-1:0]  controlWordOut;
   spread_t               spreadOut;
   int                    n_errors, n_checks, refCnt;

   deser_lock_ctrl #(.REF_LOCK_CYC(20), .TIMEOUT_LIM(64), .BLANK_LIM(40))
   dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .refClkIn(refClkIn),
      .powerDownN(powerDownN), .outputDriveEn(output_drive_en), .risingLatch(rising),
      .spreadSel(spread), .rateBandSel(band), .serialBit(serialBit),
      .serialStrobe(serialStrobe), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
      .lockN(lockN), .lockOe(lockOe), .pclkOut(pclkOut), .dataOe(dataOe),
      .videoWordOut(videoWordOut), .controlWordOut(controlWordOut),
      .videoPhaseFlag(videoPhaseFlag), .slewFast(slewFast),
      .spreadOut(spreadOut));

   serial_src src (.clk(clk), .arst_n(arst_n), .run(run), .word(word),
      .serialBit(serialBit), .serialStrobe(serialStrobe),
      .wordDone(wordDone));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      refCnt <= refCnt + 1;
      refClkIn <= refCnt[2];
      refHist <= {refHist[2:0], refClkIn};
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, datW} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = datR;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
   endtask

   task words(input int n);
      repeat (n) @(posedge clk iff wordDone);
      repeat (6) @(posedge clk);
   endtask

   task end_of_test;
      if (n_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      n_errors++;
      end_of_test();
   end

   initial
   begin
      {arst_n, powerDownN, output_drive_en, run, cyc, stb, we} = '0;
      {adr, datW, spread} = '0;
      {rising, sel} = 5'h1F;
      band = 2'h1;
      word = 20'h5_5A5A;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("lockOe", 0, lockOe);
      chk("dataOe", 0, dataOe);
      wb(0, ADR_TRANS, 0);
      chk("trans reset", TRANS_WORD_DEF, q);
      sel <= 4'h1;
      wb(1, ADR_TRANS, 32'hFFFF_FF5A);
      sel <= 4'hF;
      wb(0, ADR_TRANS, 0);
      chk("trans lane", 32'h000F_C05A, q);
      wb(1, ADR_TRANS, 32'h0005_5A5A);
      wb(0, ADR_TRANS, 0);
      chk("trans", 32'h0005_5A5A, q);
      wb(0, 4'hC, 0);
      chk("unmapped", 0, q);
      run <= 1'b1;
      output_drive_en <= 1'b1;
      repeat (17100) @(posedge clk iff serialStrobe);
      powerDownN <= 1'b1;
      repeat (8) @(posedge clk);
      chk("lockN up", 1, lockN);
      chk("lockOe up", 1, lockOe);
      chk("video low", 0, videoWordOut);
      for (int b = 1; b < 4; b++)
      begin
         band <= b[1:0];
         repeat (6) @(posedge clk);
         chk("slew", b != 1, slewFast);
      end
      for (int i = 0; i < 3000 && lockN !== 1'b0; i++) @(posedge clk);
      chk("locked", 0, lockN);
      word <= 20'h6_9A55;
      words(2);
      chk("video", 18'h1_A695, videoWordOut);
      chk("phase video", 1, videoPhaseFlag);
      word <= 20'hA_E38A;
      words(2);
      chk("control", 9'h155, controlWordOut);
      chk("phase ctrl", 0, videoPhaseFlag);
      chk("video held", 18'h1_A695, videoWordOut);
      output_drive_en <= 1'b0;
      spread <= 1'b1;
      repeat (6) @(posedge clk);
      chk("oe off data", 0, dataOe);
      chk("oe off lock", 1, lockOe);
      chk("no spread", 0, spreadOut);
      output_drive_en <= 1'b1;
      words(60);
      chk("before timeout", 0, lockN);
      words(6);
      chk("timeout", 1, lockN);
      chk("timeout ctrl", 0, controlWordOut);
      word <= 20'h5_5A5A;
      words(2);
      word <= 20'h6_9A55;
      words(2);
      chk("relock", 0, lockN);
      run <= 1'b0;
      repeat (100) @(posedge clk);
      chk("idle lock", 1, lockN);
      chk("idle video", 0, videoWordOut);
      repeat (8)
      begin
         @(posedge clk);
         chk("pclk ref", refHist[3], pclkOut);
      end
      rising <= 1'b0;
      repeat (6) @(posedge clk);
      repeat (8)
      begin
         @(posedge clk);
         chk("pclk fall", !refHist[3], pclkOut);
      end
      end_of_test();
   end
endmodule
